// *** acrb_amp_control_register_bank.v ***
// Behaviour
// - Auto sleep after 2048 consecutive zero samples
// - One nonzero sample wakes from auto sleep
// - Bit 6 switches off supply sensing
// - Software reset bit restores all registers
// - Master sleep idles all but control
// - Power control resets to 0x81
// - Gain register resets 0x01, top bits zero
`include "acrb_map.vh"

module acrb_amp_control_register_bank #(
	parameter ZERO_RUN = `ACRB_ZERO_RUN
) (
	input  wire       I_MCLK,        // System clock, 20 MHz
	input  wire       I_RST_B,       // Async reset, active low
	input  wire       I_WR_EN,       // Register write strobe
	input  wire       I_RD_EN,       // Register read strobe
	input  wire [3:0] I_ADDR,        // Register offset
	input  wire [7:0] I_WDATA,       // Write data
	input  wire       I_SMP_VALID,   // Audio sample strobe
	input  wire       I_SMP_NONZERO, // Sample value is nonzero
	input  wire [7:0] I_VSUP,        // Measured supply code
	input  wire [7:0] I_STATUS,      // Live status flags
	output reg  [7:0] O_RDATA,       // Read data
	output reg        O_RVALID,      // Read data valid pulse
	output reg        O_SLEEP,       // Blocks in low power
	output reg        O_AUTO_SLEPT,  // Auto sleep active
	output reg        O_SENSE_ON,    // Supply sense enabled
	output reg        O_BLOCK_RST,   // Internal blocks reset pulse
	output reg  [7:0] O_GAIN,        // Gain and edge control
	output reg  [7:0] O_CONV,        // Converter control
	output reg  [7:0] O_VOL,         // Volume control
	output reg  [7:0] O_SAI1,        // Serial audio control one
	output reg  [7:0] O_SAI2,        // Serial audio control two
	output reg  [7:0] O_LIM1,        // Limiter control one
	output reg  [7:0] O_LIM2,        // Limiter control two
	output reg  [7:0] O_LIM3,        // Limiter control three
	output reg  [7:0] O_FAULT        // Fault recovery control
);

	////////////////////////////////////////////////////////////////
	localparam CW = 12;

	reg  [7:0]    pwr_r;
	reg  [CW-1:0] zero_cnt_r;
	reg           soft_rst_r;
	reg  [7:0]    rdata_nxt;
	wire          wr_pwr;

	assign wr_pwr = I_WR_EN && (I_ADDR == `ACRB_OFS_PWR);

	////////////////////////////////////////////////////////////////
	// Register writes; soft reset takes one cycle to apply
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			pwr_r      <= `ACRB_RST_PWR;
			O_GAIN     <= `ACRB_RST_GAIN;
			O_CONV     <= `ACRB_RST_CONV;
			O_VOL      <= `ACRB_RST_VOL;
			O_SAI1     <= `ACRB_RST_SAI1;
			O_SAI2     <= `ACRB_RST_SAI2;
			O_LIM1     <= `ACRB_RST_LIM1;
			O_LIM2     <= `ACRB_RST_LIM2;
			O_LIM3     <= `ACRB_RST_LIM3;
			O_FAULT    <= `ACRB_RST_FAULT;
			soft_rst_r <= 1'b0;
		end else if (soft_rst_r) begin
			pwr_r      <= `ACRB_RST_PWR;
			O_GAIN     <= `ACRB_RST_GAIN;
			O_CONV     <= `ACRB_RST_CONV;
			O_VOL      <= `ACRB_RST_VOL;
			O_SAI1     <= `ACRB_RST_SAI1;
			O_SAI2     <= `ACRB_RST_SAI2;
			O_LIM1     <= `ACRB_RST_LIM1;
			O_LIM2     <= `ACRB_RST_LIM2;
			O_LIM3     <= `ACRB_RST_LIM3;
			O_FAULT    <= `ACRB_RST_FAULT;
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= wr_pwr && I_WDATA[`ACRB_BIT_SRST];
			if (I_WR_EN) begin
				case (I_ADDR)
					`ACRB_OFS_PWR:   pwr_r   <= I_WDATA & ~(8'h01 << `ACRB_BIT_SRST);
					`ACRB_OFS_GAIN:  O_GAIN  <= I_WDATA & `ACRB_GAIN_MASK;
					`ACRB_OFS_CONV:  O_CONV  <= I_WDATA;
					`ACRB_OFS_VOL:   O_VOL   <= I_WDATA;
					`ACRB_OFS_SAI1:  O_SAI1  <= I_WDATA;
					`ACRB_OFS_SAI2:  O_SAI2  <= I_WDATA;
					`ACRB_OFS_LIM1:  O_LIM1  <= I_WDATA;
					`ACRB_OFS_LIM2:  O_LIM2  <= I_WDATA;
					`ACRB_OFS_LIM3:  O_LIM3  <= I_WDATA;
					`ACRB_OFS_FAULT: O_FAULT <= I_WDATA;
					default: ;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Zero-run counter saturates so sleep holds through long silence
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			zero_cnt_r   <= {CW{1'b0}};
			O_AUTO_SLEPT <= 1'b0;
		end else if (soft_rst_r || !pwr_r[`ACRB_BIT_AUTO_EN]) begin
			zero_cnt_r   <= {CW{1'b0}};
			O_AUTO_SLEPT <= 1'b0;
		end else if (I_SMP_VALID) begin
			if (I_SMP_NONZERO) begin
				zero_cnt_r   <= {CW{1'b0}};
				O_AUTO_SLEPT <= 1'b0;
			end else if (zero_cnt_r == ZERO_RUN[CW-1:0] - 12'h001) begin
				O_AUTO_SLEPT <= 1'b1;
			end else if (!O_AUTO_SLEPT) begin
				zero_cnt_r <= zero_cnt_r + 12'h001;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Derived power outputs, registered
	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_SLEEP     <= 1'b1;
			O_SENSE_ON  <= 1'b1;
			O_BLOCK_RST <= 1'b0;
		end else begin
			O_SLEEP     <= pwr_r[`ACRB_BIT_SLEEP] || O_AUTO_SLEPT;
			O_SENSE_ON  <= !pwr_r[`ACRB_BIT_SENSE] && !pwr_r[`ACRB_BIT_SLEEP];
			O_BLOCK_RST <= soft_rst_r;
		end
	end

	////////////////////////////////////////////////////////////////
	// Read path; control interface stays live while asleep
	always @* begin
		case (I_ADDR)
			`ACRB_OFS_PWR:   rdata_nxt = pwr_r;
			`ACRB_OFS_GAIN:  rdata_nxt = O_GAIN;
			`ACRB_OFS_CONV:  rdata_nxt = O_CONV;
			`ACRB_OFS_VOL:   rdata_nxt = O_VOL;
			`ACRB_OFS_SAI1:  rdata_nxt = O_SAI1;
			`ACRB_OFS_SAI2:  rdata_nxt = O_SAI2;
			`ACRB_OFS_VSUP:  rdata_nxt = I_VSUP;
			`ACRB_OFS_LIM1:  rdata_nxt = O_LIM1;
			`ACRB_OFS_LIM2:  rdata_nxt = O_LIM2;
			`ACRB_OFS_LIM3:  rdata_nxt = O_LIM3;
			`ACRB_OFS_STAT:  rdata_nxt = I_STATUS;
			`ACRB_OFS_FAULT: rdata_nxt = O_FAULT;
			default:         rdata_nxt = 8'h00;
		endcase
	end

	always @(posedge I_MCLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			O_RDATA  <= 8'h00;
			O_RVALID <= 1'b0;
		end else begin
			O_RVALID <= I_RD_EN;
			if (I_RD_EN)
				O_RDATA <= rdata_nxt;
		end
	end

endmodule

// *** acrb_map.vh ***
`ifndef ACRB_MAP_VH
`define ACRB_MAP_VH
// Register offsets
`define ACRB_OFS_PWR      4'h0
`define ACRB_OFS_GAIN     4'h1
`define ACRB_OFS_CONV     4'h2
`define ACRB_OFS_VOL      4'h3
`define ACRB_OFS_SAI1     4'h4
`define ACRB_OFS_SAI2     4'h5
`define ACRB_OFS_VSUP     4'h6
`define ACRB_OFS_LIM1     4'h7
`define ACRB_OFS_LIM2     4'h8
`define ACRB_OFS_LIM3     4'h9
`define ACRB_OFS_STAT     4'ha
`define ACRB_OFS_FAULT    4'hb
// Reset values
`define ACRB_RST_PWR      8'h81
`define ACRB_RST_GAIN     8'h01
`define ACRB_RST_CONV     8'h32
`define ACRB_RST_VOL      8'h40
`define ACRB_RST_SAI1     8'h11
`define ACRB_RST_SAI2     8'h00
`define ACRB_RST_LIM1     8'ha4
`define ACRB_RST_LIM2     8'h51
`define ACRB_RST_LIM3     8'h22
`define ACRB_RST_FAULT    8'h18
// Power control fields
`define ACRB_BIT_AUTO_EN  7
`define ACRB_BIT_SENSE    6
`define ACRB_BIT_SRST     1
`define ACRB_BIT_SLEEP    0
// Gain register writable mask (top three bits reserved)
`define ACRB_GAIN_MASK    8'h1f
// Zero-sample run before auto sleep
`define ACRB_ZERO_RUN     2048
`endif

// *** acrb_asserts.sv ***
module acrb_chk (
	input wire       I_MCLK,
	input wire       I_RST_B,
	input wire       I_WR_EN,
	input wire       I_RD_EN,
	input wire [3:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire       I_SMP_VALID,
	input wire       I_SMP_NONZERO,
	input wire [7:0] O_RDATA,
	input wire       O_SLEEP,
	input wire       O_AUTO_SLEPT,
	input wire       O_SENSE_ON,
	input wire       O_BLOCK_RST,
	input wire [7:0] O_GAIN
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (!I_RST_B);
	sequence s_pw; I_WR_EN && I_ADDR == 4'h0 && !I_WDATA[1]; endsequence
	sequence s_rs; I_WR_EN && I_ADDR == 4'h0 && I_WDATA[1]; endsequence
	property p_zr; $rose(O_AUTO_SLEPT) |-> $past(I_SMP_VALID && !I_SMP_NONZERO); endproperty
	a_zr: assert property (p_zr) else $error("sleep no zero");
	property p_wk; I_SMP_VALID && I_SMP_NONZERO |=> !O_AUTO_SLEPT; endproperty
	a_wk: assert property (p_wk) else $error("no wake");
	property p_sn; s_pw ##0 I_WDATA[6] |-> ##2 !O_SENSE_ON; endproperty
	a_sn: assert property (p_sn) else $error("sense on");
	property p_rs; s_rs |-> ##2 O_BLOCK_RST; endproperty
	a_rs: assert property (p_rs) else $error("no reset");
	property p_ms; s_pw ##0 I_WDATA[0] |-> ##2 O_SLEEP; endproperty
	a_ms: assert property (p_ms) else $error("no sleep");
	property p_po; O_BLOCK_RST |=> O_SLEEP; endproperty
	a_po: assert property (p_po) else $error("awake");
	property p_gn; O_GAIN[7:5] == 3'h0; endproperty
	a_gn: assert property (p_gn) else $error("gain top");
	property p_rb; I_RD_EN && I_ADDR == 4'h0 |=> !O_RDATA[1]; endproperty
	a_rb: assert property (p_rb) else $error("reset bit");
endmodule
bind acrb_amp_control_register_bank acrb_chk i_acrb_chk (.*);

// *** acrb_host.sv ***
module acrb_host (
	input  wire        clk,   // Clock
	input  wire  [7:0] rdata, // Read data
	output logic       wr,    // Write strobe
	output logic       rd,    // Read strobe
	output logic [3:0] addr,  // Offset
	output logic [7:0] wdata  // Write data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {wr, rd, addr, wdata} = '0;
	task automatic xfer(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk) #1;
		{wr, rd, addr, wdata} = {w, !w, a, d};
		@(posedge clk) #1;
		{wr, rd} = 2'b00;
		{addr, wdata} = ~{a, d}; // Released lines must not hold stale values
		@(posedge clk) #1;
		q = rdata;
	endtask
endmodule

// *** testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ZR = 8; // Short run keeps the sim quick
	logic clk = 0, rst_b = 0, sv = 0, snz = 0, wr, rd, slp, asl, sns, rv;
	logic [3:0] ad;
	logic [7:0] vs = 0, st = 0, wd, rdat, q, d, m [12], po [12];
	int bad_count = 0, tests_run = 0, rv_n = 0, rd_n = 0;
	always #25 clk = ~clk;
	always @(posedge clk) if (rv === 1'b1) rv_n++;
	acrb_host i_acrb_host (.clk(clk), .rdata(rdat), .wr(wr), .rd(rd), .addr(ad), .wdata(wd));
	acrb_amp_control_register_bank #(.ZERO_RUN(ZR)) i_acrb_amp_control_register_bank (.I_MCLK(clk),
		.I_RST_B(rst_b), .I_WR_EN(wr), .I_RD_EN(rd), .I_ADDR(ad), .I_WDATA(wd), .I_SMP_VALID(sv),
		.I_SMP_NONZERO(snz), .I_VSUP(vs), .I_STATUS(st), .O_RDATA(rdat), .O_RVALID(rv), .O_SLEEP(slp),
		.O_AUTO_SLEPT(asl), .O_SENSE_ON(sns), .O_BLOCK_RST(), .O_GAIN(po[1]), .O_CONV(po[2]), .O_VOL(po[3]),
		.O_SAI1(po[4]), .O_SAI2(po[5]), .O_LIM1(po[7]), .O_LIM2(po[8]), .O_LIM3(po[9]), .O_FAULT(po[11]));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (bad_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic void rstm();
		m = '{8'h81, 8'h01, 8'h32, 8'h40, 8'h11, 8'h00, 8'h00, 8'ha4, 8'h51, 8'h22, 8'h00, 8'h18};
	endfunction
	task automatic smp(input logic nz);
		@(posedge clk) #1;
		{sv, snz} = {1'b1, nz};
		@(posedge clk) #1;
		sv = 0;
	endtask
	task automatic all(input logic w);
		for (int a = 0; a < 16; a++) begin
			d = $urandom & 8'hfd;
			i_acrb_host.xfer(w, a[3:0], d, q);
			if (!w) chk(q, a == 6 ? vs : a == 10 ? st : a > 11 ? 8'h00 : m[a]);
			if (!w) rd_n++;
			if (!w && a > 0 && a < 12 && a != 6 && a != 10) chk(po[a], m[a]);
			else if (a < 12 && a != 6 && a != 10) m[a] = a == 1 ? d & 8'h1f : d;
		end
	endtask
	initial begin
		void'($urandom(55));
		vs = $urandom;
		st = $urandom;
		repeat (8) @(posedge clk);
		#1 rst_b = 1;
		rstm();
		all(0);
		repeat (3) begin
			all(1);
			all(0);
		end
		i_acrb_host.xfer(1, 4'h0, 8'h80, q);
		repeat (ZR - 1) smp(0);
		chk({7'h0, asl}, 8'h00);
		smp(0);
		repeat (2) @(posedge clk);
		#1 chk({6'h0, asl, slp}, 8'h03);
		smp(1);
		@(posedge clk) #1 chk({7'h0, asl}, 8'h00);
		i_acrb_host.xfer(1, 4'h0, 8'h40, q);
		chk({7'h0, sns}, 8'h00);
		i_acrb_host.xfer(1, 4'h0, 8'h00, q);
		chk({6'h0, sns, slp}, 8'h02);
		i_acrb_host.xfer(1, 4'h0, 8'h01, q);
		chk({7'h0, slp}, 8'h01);
		i_acrb_host.xfer(1, 4'h0, 8'h02, q);
		rstm();
		all(0);
		chk(rv_n[7:0], rd_n[7:0]);
		results();
	end
	initial begin
		#100us;
		bad_count++;
		results();
	end
endmodule
